// [rtl/sfp_slave_port.sv]
/*
 * Serial peripheral slave frame port: shift logic on the serial clock,
 * frame check, timeout and standby tracking on the system clock.
 * Assumes the host keeps the serial clock low around select edges and
 * holds rsp_word steady from select until release.
 */
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_slave_port (
	// System clock and reset
	input  wire logic                        clk_sys,
	input  wire logic                        rst,
	// Serial link pins
	input  wire logic                        sck,
	input  wire logic                        csn_n,
	input  wire logic                        sdi,
	output logic                             sdo_o,
	output logic                             sdo_oe,
	// Device side
	input  wire logic [`SFP_FRAME_BITS-1:0]  rsp_word,
	output logic [`SFP_FRAME_BITS-1:0]       cmd_word,
	output logic                             cmd_valid,
	output logic                             standby,
	output logic                             rst_ind,
	output logic                             tmo_flag
);

	//------------------------------------------------------------
	// Link domain: receive shift and bit count
	//------------------------------------------------------------
	logic                        link_rst;
	logic [`SFP_CNT_W-1:0]       cnt_r;
	logic [`SFP_CNT_W-1:0]       cnt_nxt;
	logic [`SFP_FRAME_BITS-2:0]  sh_r;
	logic [`SFP_FRAME_BITS-2:0]  sh_nxt;
	logic [`SFP_FRAME_BITS-1:0]  hold_r;
	logic [`SFP_FRAME_BITS-1:0]  hold_nxt;
	logic                        full_tgl_r;
	logic                        full_tgl_nxt;
	logic                        ovf_tgl_r;
	logic                        ovf_tgl_nxt;
	logic                        act_tgl_r;
	logic [`SFP_CNT_W-1:0]       oidx_r;
	logic [`SFP_CNT_W-1:0]       oidx_nxt;
	logic [`SFP_FRAME_BITS-1:0]  tx_r;
	logic                        tmo_r;

	// Deselect holds the link logic cleared, so stray clocks do nothing
	assign link_rst = rst | csn_n;

	// Count saturates past the frame so long frames stay invalid
	always_comb
	begin
		cnt_nxt      = cnt_r;
		sh_nxt       = {sh_r[`SFP_FRAME_BITS-3:0], sdi};
		hold_nxt     = hold_r;
		full_tgl_nxt = full_tgl_r;
		ovf_tgl_nxt  = ovf_tgl_r;
		if (cnt_r == `SFP_CNT_LAST)
		begin
			hold_nxt     = {sh_r, sdi};
			full_tgl_nxt = ~full_tgl_r;
		end
		if (cnt_r == `SFP_CNT_FULL)
			ovf_tgl_nxt = ~ovf_tgl_r;
		if (cnt_r != `SFP_CNT_OVF)
			cnt_nxt = cnt_r + `SFP_CNT_W'(1);
	end

	// Bit position and shift, cleared at each select
	always_ff @(posedge sck or posedge link_rst)
	begin
		if (link_rst)
		begin
			cnt_r <= '0;
			sh_r  <= '0;
		end
		else
		begin
			cnt_r <= cnt_nxt;
			sh_r  <= sh_nxt;
		end
	end

	// Frame result and events survive release for the system side
	always_ff @(posedge sck or posedge rst)
	begin
		if (rst)
		begin
			hold_r     <= '0;
			full_tgl_r <= 1'b0;
			ovf_tgl_r  <= 1'b0;
			act_tgl_r  <= 1'b0;
		end
		else if (!csn_n)
		begin
			hold_r     <= hold_nxt;
			full_tgl_r <= full_tgl_nxt;
			ovf_tgl_r  <= ovf_tgl_nxt;
			act_tgl_r  <= ~act_tgl_r;
		end
	end

	//------------------------------------------------------------
	// Link domain: transmit on the falling edge
	//------------------------------------------------------------
	always_comb
	begin
		oidx_nxt = oidx_r;
		if (oidx_r != `SFP_CNT_LAST)
			oidx_nxt = oidx_r + `SFP_CNT_W'(1);
	end

	always_ff @(negedge sck or posedge link_rst)
	begin
		if (link_rst)
			oidx_r <= '0;
		else
			oidx_r <= oidx_nxt;
	end

	// Output mux of held bits; first bit is ready before the first rise
	assign sdo_o  = tx_r[`SFP_CNT_LAST - oidx_r];
	// Pin-level gating so release is immediate, not after a sync delay
	assign sdo_oe = ~csn_n & ~tmo_r & ~rst;

	//------------------------------------------------------------
	// System domain: three-stage synchronisers
	//------------------------------------------------------------
	// Bits: 3 act, 2 ovf, 1 full, 0 select
	logic [3:0] s1_r;
	logic [3:0] s2_r;
	logic [3:0] s3_r;
	logic [3:0] flt_r;
	logic [3:0] flt_nxt;

	// A change counts once stages two and three agree
	always_comb
	begin
		for (int i = 0; i < 4; i++)
			flt_nxt[i] = (s2_r[i] == s3_r[i]) ? s2_r[i] : flt_r[i];
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s1_r  <= 4'h1;
			s2_r  <= 4'h1;
			s3_r  <= 4'h1;
			flt_r <= 4'h1;
		end
		else
		begin
			s1_r  <= {act_tgl_r, ovf_tgl_r, full_tgl_r, csn_n};
			s2_r  <= s1_r;
			s3_r  <= s2_r;
			flt_r <= flt_nxt;
		end
	end

	//------------------------------------------------------------
	// System domain: frame control
	//------------------------------------------------------------
	sfp_pkg::sfp_state_t         st_r;
	sfp_pkg::sfp_state_t         st_nxt;
	logic                        sel_d_r;
	logic                        full_seen_r;
	logic                        full_seen_nxt;
	logic                        ovf_seen_r;
	logic                        ovf_seen_nxt;
	logic                        act_seen_r;
	logic [`SFP_TMO_W-1:0]       tmo_cnt_r;
	logic [`SFP_TMO_W-1:0]       tmo_cnt_nxt;
	logic                        tmo_nxt;
	logic [`SFP_FRAME_BITS-1:0]  tx_nxt;
	logic [`SFP_FRAME_BITS-1:0]  cmd_nxt;
	logic                        cmd_valid_nxt;
	logic                        rst_ind_nxt;
	logic                        sel_fall;
	logic                        sel_rise;
	logic                        frame_ok;

	assign sel_fall = sel_d_r & ~flt_r[0];
	assign sel_rise = ~sel_d_r & flt_r[0];
	// One full frame, no overflow, no timeout
	assign frame_ok = (flt_r[1] != full_seen_r) &
			  (flt_r[2] == ovf_seen_r) & ~tmo_r;

	always_comb
	begin
		st_nxt        = st_r;
		full_seen_nxt = full_seen_r;
		ovf_seen_nxt  = ovf_seen_r;
		tmo_cnt_nxt   = tmo_cnt_r;
		tmo_nxt       = tmo_r;
		tx_nxt        = tx_r;
		cmd_nxt       = cmd_word;
		cmd_valid_nxt = 1'b0;
		rst_ind_nxt   = rst_ind;
		// Response is frozen while the link may shift it out
		if (flt_r[0] && !sel_rise)
			tx_nxt = rsp_word;
		case (st_r)
			sfp_pkg::SFP_STBY:
				if (sel_fall)
					st_nxt = sfp_pkg::SFP_XFER;
			sfp_pkg::SFP_IDLE:
				if (sel_fall)
				begin
					st_nxt      = sfp_pkg::SFP_XFER;
					tmo_cnt_nxt = '0;
				end
			sfp_pkg::SFP_XFER:
			begin
				// Activity restarts the quiet-time count
				if (flt_r[3] != act_seen_r)
					tmo_cnt_nxt = '0;
				else if (tmo_cnt_r != `SFP_TMO_W'(`SFP_TMO_CYC))
					tmo_cnt_nxt = tmo_cnt_r + `SFP_TMO_W'(1);
				else
					tmo_nxt = 1'b1;
				if (sel_rise)
				begin
					st_nxt        = sfp_pkg::SFP_IDLE;
					tmo_nxt       = 1'b0;
					tmo_cnt_nxt   = '0;
					rst_ind_nxt   = 1'b0;
					full_seen_nxt = flt_r[1];
					ovf_seen_nxt  = flt_r[2];
					if (frame_ok)
					begin
						cmd_nxt       = hold_r;
						cmd_valid_nxt = 1'b1;
					end
				end
			end
			default:
				st_nxt = sfp_pkg::SFP_STBY;
		endcase
	end

	// Register stage of the frame control
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			st_r        <= sfp_pkg::SFP_STBY;
			sel_d_r     <= 1'b1;
			full_seen_r <= 1'b0;
			ovf_seen_r  <= 1'b0;
			act_seen_r  <= 1'b0;
			tmo_cnt_r   <= '0;
			tmo_r       <= 1'b0;
			tx_r        <= '0;
			cmd_word    <= '0;
			cmd_valid   <= 1'b0;
			rst_ind     <= 1'b1;
		end
		else
		begin
			st_r        <= st_nxt;
			sel_d_r     <= flt_r[0];
			full_seen_r <= full_seen_nxt;
			ovf_seen_r  <= ovf_seen_nxt;
			act_seen_r  <= flt_r[3];
			tmo_cnt_r   <= tmo_cnt_nxt;
			tmo_r       <= tmo_nxt;
			tx_r        <= tx_nxt;
			cmd_word    <= cmd_nxt;
			cmd_valid   <= cmd_valid_nxt;
			rst_ind     <= rst_ind_nxt;
		end
	end

	assign standby  = st_r[0];
	assign tmo_flag = tmo_r;

endmodule

// [rtl/sfp_cfg.svh]
/*
 * Constants of the serial frame port: frame length, counter widths and
 * the link timeout. Assumes a 20 MHz system clock.
 */
`ifndef SFP_CFG_SVH
`define SFP_CFG_SVH

//------------------------------------------------------------
// Frame layout
//------------------------------------------------------------
`define SFP_FRAME_BITS 24
`define SFP_CNT_W      5
`define SFP_CNT_LAST   5'h17
`define SFP_CNT_FULL   5'h18
`define SFP_CNT_OVF    5'h19

//------------------------------------------------------------
// Timing
//------------------------------------------------------------
`define SFP_CLK_NS     50
`define SFP_TMO_NS     10000
`define SFP_TMO_CYC    ((`SFP_TMO_NS + `SFP_CLK_NS - 1) / `SFP_CLK_NS)
`define SFP_TMO_W      8

`endif

// [rtl/sfp_pkg.sv]
/*
 * Types of the serial frame port.
 * Assumes sfp_cfg.svh is compiled alongside.
 */
package sfp_pkg;

	//------------------------------------------------------------
	// System-side states, one-hot
	//------------------------------------------------------------
	typedef enum logic [2:0] {
		SFP_STBY = 3'h1,
		SFP_IDLE = 3'h2,
		SFP_XFER = 3'h4
	} sfp_state_t;

endpackage

// [verification/sfp_slave_port_props.sv]
/*
 * Checker of the serial frame port: pins and device-side outputs.
 * Bound to sfp_slave_port from the bench; sees its ports only.
 */
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module sfp_port_chk (
	// Clock and reset
	input wire logic                       clk_sys,
	input wire logic                       rst,
	// Link pins
	input wire logic                       csn_n,
	input wire logic                       sdo_oe,
	// Device side
	input wire logic [`SFP_FRAME_BITS-1:0] cmd_word,
	input wire logic                       cmd_valid,
	input wire logic                       standby,
	input wire logic                       rst_ind,
	input wire logic                       tmo_flag
);
	//------------------------------------------------------------
	// Properties
	//------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_oe_off; csn_n |-> !sdo_oe; endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("output driven while deselected");
	property p_oe_on; $fell(csn_n) |-> sdo_oe; endproperty
	a_oe_on: assert property (p_oe_on)
		else $error("output not driven after select");
	property p_cv_one; cmd_valid |=> !cmd_valid; endproperty
	a_cv_one: assert property (p_cv_one)
		else $error("command pulse too long");
	property p_cv_rel; cmd_valid |-> csn_n; endproperty
	a_cv_rel: assert property (p_cv_rel)
		else $error("command executed while selected");
	property p_cw_hold; $changed(cmd_word) |-> cmd_valid; endproperty
	a_cw_hold: assert property (p_cw_hold)
		else $error("command word changed without pulse");
	property p_stby_keep; !standby |=> !standby; endproperty
	a_stby_keep: assert property (p_stby_keep)
		else $error("standby re-entered");
	property p_stby_wake; $fell(standby) |-> !csn_n; endproperty
	a_stby_wake: assert property (p_stby_wake)
		else $error("standby left without select");
	property p_rsti_end; $fell(rst_ind) |-> csn_n; endproperty
	a_rsti_end: assert property (p_rsti_end)
		else $error("reset flag cleared inside frame");
	property p_tmo_oe; tmo_flag |-> !sdo_oe; endproperty
	a_tmo_oe: assert property (p_tmo_oe)
		else $error("output driven after timeout");
	// Main scenarios reached
	c_cmd: cover property (cmd_valid);
	c_tmo: cover property ($rose(tmo_flag));
	c_wake: cover property ($fell(standby));
endmodule

// [verification/sfp_host_model.sv]
/*
 * Host model: serial master making clock, select and input data.
 * Clock period 64 ns, standing low outside frames except during noise bursts.
 */
`timescale 1ns/1ps

module sfp_host_model (
	// Link pins
	output logic      sck,
	output logic      csn_n,
	output logic      sdi,
	input  wire logic sdo_o,
	input  wire logic sdo_oe
);
	initial
	begin
		sck = 1'b0;
		csn_n = 1'b1;
		sdi = 1'b0;
	end
	// One frame of n bits, stalling gap ns before bit 5
	task automatic frame(input int n, input logic [23:0] d,
		input int gap, output logic [23:0] q);
		q = 24'h0;
		csn_n = 1'b0;
		#32;
		for (int i = 0; i < n; i++)
		begin
			if (i == 5)
				#(gap);
			sdi = (i < 24) ? d[23 - i] : ~sdi;
			#32 sck = 1'b1;
			// Released line reads as the inverse of the last bit
			q = {q[22:0], sdo_oe ? sdo_o : ~q[0]};
			#32 sck = 1'b0;
		end
		#32 csn_n = 1'b1;
		sdi = ~sdi;
		#400;
	endtask
	// Clock and data noise while deselected
	task automatic noise(input int n);
		repeat (n)
		begin
			#32 sck = 1'b1;
			sdi = ~sdi;
			#32 sck = 1'b0;
		end
	endtask
endmodule

// [verification/spi_slave_frame_port_tb_top.sv]
/*
 * Bench of the serial frame port with a host model on the link.
 * Assumes sfp_cfg.svh on the include path.
 */
`timescale 1ns/1ps
`include "sfp_cfg.svh"

module spi_slave_frame_port_tb_top;
	logic        clk_sys, rst, sck, csn_n, sdi, sdo_o, sdo_oe;
	logic        cmd_valid, standby, rst_ind, tmo_flag;
	logic [23:0] rsp_word, cmd_word, got;
	logic [23:0] exp_q[$];
	int          err_total = 0;
	int          n_tests = 0;
	int          seed = 84214;

	initial
	begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	sfp_slave_port i_sfp_slave_port (.clk_sys(clk_sys), .rst(rst),
		.sck(sck), .csn_n(csn_n), .sdi(sdi), .sdo_o(sdo_o),
		.sdo_oe(sdo_oe), .rsp_word(rsp_word), .cmd_word(cmd_word),
		.cmd_valid(cmd_valid), .standby(standby), .rst_ind(rst_ind),
		.tmo_flag(tmo_flag));
	sfp_host_model i_sfp_host_model (.sck(sck), .csn_n(csn_n),
		.sdi(sdi), .sdo_o(sdo_o), .sdo_oe(sdo_oe));

	//------------------------------------------------------------
	// Compare and report
	//------------------------------------------------------------
	task automatic chk24(input logic [23:0] a, input logic [23:0] e);
		n_tests++;
		if (a !== e)
		begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic chk1(input logic a, input logic e);
		chk24({23'h0, a}, {23'h0, e});
	endtask
	task final_report;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Monitor off the edge, so registered outputs have settled
	always @(negedge clk_sys)
		if (cmd_valid === 1'b1)
		begin
			if (exp_q.size() == 0)
				chk1(1'b1, 1'b0);
			else
				chk24(cmd_word, exp_q.pop_front());
		end
	// Frame of n bits; only whole unstalled frames are expected
	task automatic run(input int n, input int gap);
		logic [23:0] d;
		d = 24'($random(seed));
		@(negedge clk_sys);
		rsp_word = 24'($random(seed));
		repeat (6) @(negedge clk_sys);
		if (n == 24 && gap == 0)
			exp_q.push_back(d);
		i_sfp_host_model.frame(n, d, gap, got);
		if (n == 24 && gap == 0)
			chk24(got, rsp_word);
	endtask

	//------------------------------------------------------------
	// Main sequence and watchdog
	//------------------------------------------------------------
	initial
	begin
		rst = 1'b1;
		rsp_word = 24'h0;
		repeat (6) @(negedge clk_sys);
		chk1(standby, 1'b1);
		chk1(sdo_oe, 1'b0);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		i_sfp_host_model.noise(8);
		chk1(standby, 1'b1);
		run(24, 0);
		chk1(standby, 1'b0);
		chk1(rst_ind, 1'b0);
		run(23, 0);
		run(25, 0);
		fork
			run(24, 15000);
			begin
				#12000;
				chk1(sdo_oe, 1'b0);
				chk1(tmo_flag, 1'b1);
			end
		join
		chk1(tmo_flag, 1'b0);
		repeat (3) run(24, 0);
		chk1(sdo_oe, 1'b0);
		repeat (10) @(negedge clk_sys);
		chk24(24'(exp_q.size()), 24'h0);
		final_report();
	end
	initial
	begin
		#200000;
		err_total++;
		final_report();
	end
endmodule

bind sfp_slave_port sfp_port_chk i_sfp_port_chk (.clk_sys(clk_sys),
	.rst(rst), .csn_n(csn_n), .sdo_oe(sdo_oe), .cmd_word(cmd_word),
	.cmd_valid(cmd_valid), .standby(standby), .rst_ind(rst_ind),
	.tmo_flag(tmo_flag));
